// ### bench/bc_condition_flag_unit_tb.sv
// self-checking bench of the condition flag unit
`timescale 1ns/1ps
`default_nettype none
module bc_condition_flag_unit_tb import bc_flag_pkg::*; ;
	localparam int C2 = 40;
	localparam int C3 = 60;
	int cyc [4] = '{TIMEOUT_CYC_0, TIMEOUT_CYC_1, C2, C3};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic op_valid = 1'b0;
	seq_op_e op = op_none;
	logic [15:0] op_param = 16'h0, frame_timer = 16'h0, msg_timer = 16'h0;
	logic [7:0] flag_set = 8'h00, flag_clr = 8'h00, flag_tgl = 8'h00, gp_flags, v;
	logic cond_req = 1'b0;
	logic [4:0] cond_sel = 5'h00;
	logic cond_valid, cond_true, irq;
	logic parity_midbit, status_midsync, msg_done, msg_format_error;
	msg_kind_e msg_kind;
	logic msg_addr_mismatch = 1'b0, msg_loop_fail = 1'b0, msg_masked_status = 1'b0;
	logic [1:0] msg_retry = 2'h0;
	int mismatches = 0, n_tests = 0;

	bc_condition_flag_unit #(.TIMEOUT_CYC_2(C2), .TIMEOUT_CYC_3(C3)) dut (
		.clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .op_valid, .op, .op_param, .frame_timer, .msg_timer, .flag_set,
		.flag_clr, .flag_tgl, .cond_req, .cond_sel, .cond_valid, .cond_true,
		.parity_midbit, .status_midsync, .msg_done, .msg_kind, .msg_format_error,
		.msg_addr_mismatch, .msg_loop_fail, .msg_masked_status, .msg_retry,
		.gp_flags, .irq
	);

	rt_model rt (
		.clk, .parity_midbit, .status_midsync, .msg_done, .msg_kind, .msg_format_error
	);

	initial begin
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			mismatches++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic do_op(input seq_op_e o, input logic [15:0] p);
		@(posedge clk);
		op_valid <= 1'b1;
		op <= o;
		op_param <= p;
		@(posedge clk);
		op_valid <= 1'b0;
		@(posedge clk);
	endtask : do_op

	task automatic cond(input logic [4:0] s, input logic e);
		int i;
		@(posedge clk);
		cond_req <= 1'b1;
		cond_sel <= s;
		@(posedge clk);
		cond_req <= 1'b0;
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			if (cond_valid === 1'b1) break;
		end
		if (i == 8) begin
			mismatches++;
			end_sim();
		end
		chk(cond_true, e);
	endtask : cond

	task automatic msg(input msg_kind_e k, input logic e, input int r, input int l);
		rt.run(k, e, r, l);
		repeat (2) @(posedge clk);
	endtask : msg

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		chk(gp_flags, GP_RESET);
		chk(irq, 1'b0);
		apb(1'b0, ADDR_CONFIG, 32'h0);
		chk(rd[1:0], TSEL_RESET);
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk(rd[2:0], IRQ_RESET);
		apb(1'b1, 8'h40, 32'hffff_ffff);
		chk(err, 1'b1);
		// compare results: below, equal and above the timer
		msg_timer <= 16'h0100;
		frame_timer <= 16'h0200;
		do_op(compare_message_timer_op, 16'h00ff);
		chk(gp_flags, 8'h01);
		do_op(compare_message_timer_op, 16'h0100);
		chk(gp_flags, 8'h02);
		do_op(compare_message_timer_op, 16'h0101);
		chk(gp_flags, 8'h00);
		do_op(compare_frame_timer_op, 16'h0200);
		chk(gp_flags[1], 1'b1);
		do_op(compare_frame_timer_op, 16'h0201);
		chk(gp_flags[1], 1'b0);
		flag_set <= 8'hff;
		do_op(execute_message_op, 16'h0000);
		chk(gp_flags[1], 1'b0);
		do_op(flag_update_op, 16'h0000);
		chk(gp_flags, 8'hff);
		flag_set <= 8'h00;
		flag_tgl <= 8'hff;
		do_op(flag_update_op, 16'h0000);
		chk(gp_flags, 8'h03);
		flag_tgl <= 8'h00;
		flag_clr <= 8'h01;
		do_op(flag_update_op, 16'h0000);
		chk(gp_flags, 8'h02);
		flag_clr <= 8'h00;
		// host side: set, toggle, clear through the flag register
		apb(1'b1, ADDR_GP_FLAGS, 32'h0000_00a4);
		apb(1'b1, ADDR_GP_FLAGS, 32'h00ff_0000);
		apb(1'b1, ADDR_GP_FLAGS, 32'h0000_0a00);
		apb(1'b0, ADDR_GP_FLAGS, 32'h0);
		chk(rd[7:0], 8'h50);
		v = 8'h50;
		for (int i = 0; i < 8; i++) begin
			cond(5'(i), v[i]);
			cond(5'(i) | 5'h10, ~v[i]);
		end
		cond(COND_ALWAYS, 1'b1);
		cond(COND_NEVER, 1'b0);
		// every message kind, error free
		for (int k = 0; k < 6; k++) begin
			msg(msg_kind_e'(k), 1'b0, 10, 30);
			cond({1'b0, COND_GBT}, k inside {1, 2, 5});
		end
		cond({1'b0, COND_NO_RESPONSE_COND}, 1'b0);
		cond({1'b1, COND_NO_RESPONSE_COND}, 1'b1);
		cond({1'b0, COND_BAD}, 1'b0);
		msg(kind_rt_to_rt, 1'b1, 10, 30);
		cond({1'b0, COND_FMT}, 1'b1);
		cond({1'b0, COND_GBT}, 1'b0);
		cond({1'b0, COND_BAD}, 1'b1);
		msg_loop_fail <= 1'b1;
		msg(kind_rt_to_bc, 1'b0, 10, 30);
		cond({1'b0, COND_GBT}, 1'b1);
		cond({1'b0, COND_BAD}, 1'b1);
		msg_loop_fail <= 1'b0;
		msg_masked_status <= 1'b1;
		msg(kind_rt_to_bc, 1'b0, 10, 30);
		cond({1'b0, COND_BAD}, 1'b0);
		msg_masked_status <= 1'b0;
		msg_addr_mismatch <= 1'b1;
		msg(kind_rt_to_bc, 1'b0, 10, 30);
		cond({1'b0, COND_FMT}, 1'b1);
		msg_addr_mismatch <= 1'b0;
		// reply just inside and just past each timeout select
		apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
		apb(1'b1, ADDR_IRQ_MASK, 32'h4);
		for (int s = 0; s < 4; s++) begin
			// status is sticky, so the last late reply must be cleared first
			apb(1'b1, ADDR_IRQ_STATUS, 32'h4);
			apb(1'b1, ADDR_CONFIG, 32'(s));
			msg(kind_rt_to_bc, 1'b0, cyc[s] - 3, cyc[s] + 10);
			cond({1'b0, COND_NO_RESPONSE_COND}, 1'b0);
			chk(irq, 1'b0);
			msg(kind_rt_to_bc, 1'b0, cyc[s] + 3, cyc[s] + 10);
			cond({1'b0, COND_NO_RESPONSE_COND}, 1'b1);
		end
		cond({1'b0, COND_BAD}, 1'b1);
		cond({1'b0, COND_GBT}, 1'b0);
		chk(gp_flags, 8'h50);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h4);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_IRQ_STATUS, 32'h4);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd[IRQ_NO_RESPONSE_COND], 1'b0);
		end_sim();
	end
endmodule : bc_condition_flag_unit_tb
`default_nettype wire

// ### bench/rt_model.sv
// remote terminal model: bus word timing and message result
`timescale 1ns/1ps
`default_nettype none
module rt_model import bc_flag_pkg::*; (
	// clock
	input wire logic clk,
	// word timing and message result
	output logic parity_midbit,
	output logic status_midsync,
	output logic msg_done,
	output var msg_kind_e msg_kind,
	output logic msg_format_error
);
	initial begin
		parity_midbit = 1'b0;
		status_midsync = 1'b0;
		msg_done = 1'b0;
		msg_kind = kind_bc_to_rt;
		msg_format_error = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// responded_cond 0 is a silent terminal; a late reply still pulses, as on a real bus
	task automatic run(input msg_kind_e k, input logic e, input int responded_cond, input int len);
		@(posedge clk);
		parity_midbit <= 1'b1;
		@(posedge clk);
		parity_midbit <= 1'b0;
		for (int i = 1; i < len; i++) begin
			@(posedge clk);
			status_midsync <= (i == responded_cond);
		end
		@(posedge clk);
		status_midsync <= 1'b0;
		msg_done <= 1'b1;
		msg_kind <= k;
		msg_format_error <= e;
		@(posedge clk);
		msg_done <= 1'b0;
		// result lines are only meaningful with done, so scramble them after
		msg_kind <= msg_kind_e'(~k);
		msg_format_error <= ~e;
	endtask : run
endmodule : rt_model
`default_nettype wire

// ### src/bc_condition_flag_unit.sv
// condition flags of the bc message sequencer, with apb registers
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: execute-message may be gated only by always/never, general or compare flags.
// R2: host leaves the gating general flag alone while its message runs.
// R3: compare flags change on frame or message timer compare.
// R4: message compare sets bit 0 when parameter below timer, else clears.
// R5: either compare sets bit 1 on equality, clears it otherwise.
// R6: bits 0 and 1 are also general flags, set or cleared by flag op.
// R7: flag op can set, clear or toggle general flags 2 through 7.
// R8: host flag register acts on general flags like the flag op.
// R9: condition bit 4 set selects the inverse sense.
// R10: code 8 true when terminal did not answer in time.
// R11: timeout runs from parity mid-bit to status mid-sync.
// R12: timeout selectable 18.5, 22.5, 50.5 or 130 us by two bits.
// R13: code 9 true on validation error or wrong status address.
// R14: code A set after error-free rt-bc, rt-rt or transmit mode data.
// R15: code A cleared after any invalid message.
// R16: code A zero after bc-rt or receive/no-data mode codes; loop test ignored.
// R17: for rt-rt, code A shows the transmitting part was error-free.
// R18: code C flags format error, loop failure or no response only.
// R19: code F always true, or never with bit 4 set.
module bc_condition_flag_unit import bc_flag_pkg::*; #(
	parameter int unsigned TIMEOUT_CYC_2 = TIMEOUT_NS_2 / CLK_NS,
	parameter int unsigned TIMEOUT_CYC_3 = TIMEOUT_NS_3 / CLK_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sequencer instruction
	input wire logic op_valid,
	input wire seq_op_e op,
	input wire logic [15:0] op_param,
	input wire logic [15:0] frame_timer,
	input wire logic [15:0] msg_timer,
	input wire logic [7:0] flag_set,
	input wire logic [7:0] flag_clr,
	input wire logic [7:0] flag_tgl,
	// condition test
	input wire logic cond_req,
	input wire logic [4:0] cond_sel,
	output logic cond_valid,
	output logic cond_true,
	// bus word timing
	input wire logic parity_midbit,
	input wire logic status_midsync,
	// message result
	input wire logic msg_done,
	input wire msg_kind_e msg_kind,
	input wire logic msg_format_error,
	input wire logic msg_addr_mismatch,
	input wire logic msg_loop_fail,
	input wire logic msg_masked_status,
	input wire logic [1:0] msg_retry,
	// flags and interrupt
	output logic [7:0] gp_flags,
	output logic irq
);

	typedef struct packed {
		logic [7:0] gp;
		logic no_response_cond;
		logic fmt;
		logic gbt;
		logic masked;
		logic bad;
		logic [1:0] retry;
		logic [1:0] tsel;
		logic [2:0] ists;
		logic [2:0] imask;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic cvalid;
		logic ctrue;
		logic irq;
	} state_s;

	state_s s_q, s_d;
	responded_cond_timer_if tif();

	logic access;
	logic host_wr;
	logic is_cmp;
	logic [15:0] cmp_val;
	logic [15:0] cond_vec;
	logic fmt_any;
	logic gbt_kind;
	logic cond_pick;

	responded_cond_timeout_timer #(
		.CYC_0(TIMEOUT_CYC_0),
		.CYC_1(TIMEOUT_CYC_1),
		.CYC_2(TIMEOUT_CYC_2),
		.CYC_3(TIMEOUT_CYC_3)
	) u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.tif(tif)
	);

	assign tif.start = parity_midbit; // R11
	assign tif.stop = status_midsync; // R11
	assign tif.sel = s_q.tsel; // R12

	////////////////////////////////////////////////////////////////////////
	// decode

	assign access = psel && penable;
	assign host_wr = access && s_q.ready && pwrite && paddr == ADDR_GP_FLAGS;
	assign is_cmp = op_valid &&
		(op == compare_frame_timer_op || op == compare_message_timer_op);
	// frame compare uses the frame timer, message compare the message timer
	assign cmp_val = (op == compare_frame_timer_op) ? frame_timer : msg_timer;
	assign fmt_any = msg_format_error || msg_addr_mismatch; // R13
	// transfers where the terminal sends data
	assign gbt_kind = msg_kind == kind_rt_to_bc || msg_kind == kind_rt_to_rt ||
		msg_kind == kind_mode_tx_data;
	assign cond_vec = {1'b1, s_q.retry[1], s_q.retry[0], s_q.bad, s_q.masked,
		s_q.gbt, s_q.fmt, s_q.no_response_cond, s_q.gp}; // R19
	assign cond_pick = cond_vec[cond_sel[3:0]] ^ cond_sel[4]; // R9

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [2:0] iset;
		logic [2:0] iclr;
		iset = '0;
		iclr = '0;
		s_d = s_q;

		// sequencer flag op: set, then clear, then toggle
		if (op_valid && op == flag_update_op) begin
			s_d.gp = ((s_d.gp | flag_set) & ~flag_clr) ^ (flag_tgl & TOGGLE_MASK); // R6 R7
		end
		if (is_cmp) begin
			s_d.gp[0] = op_param < cmp_val; // R3 R4
			s_d.gp[1] = op_param == cmp_val; // R3 R5
			iset[IRQ_CMP] = 1'b1;
		end

		// message outcome, latched at the end of each message
		if (msg_done) begin
			s_d.no_response_cond = tif.no_response; // R10
			s_d.fmt = fmt_any; // R13
			// rt-rt errors are those of the transmitting terminal
			s_d.gbt = gbt_kind && !fmt_any && !tif.no_response; // R14 R15 R16 R17
			s_d.bad = fmt_any || msg_loop_fail || tif.no_response; // R18
			s_d.masked = msg_masked_status;
			s_d.retry = msg_retry;
			iset[IRQ_BAD] = fmt_any || msg_loop_fail || tif.no_response;
			iset[IRQ_NO_RESPONSE_COND] = tif.no_response;
		end

		// apb: one wait state, data captured with pready
		s_d.ready = 1'b0;
		s_d.slverr = 1'b0;
		if (access && !s_q.ready) begin
			s_d.ready = 1'b1;
			case (paddr)
				ADDR_GP_FLAGS: s_d.rdata = {24'h000000, s_q.gp};
				ADDR_COND: s_d.rdata = {16'h0000, cond_vec};
				ADDR_CONFIG: s_d.rdata = {30'h00000000, s_q.tsel};
				ADDR_IRQ_STATUS: s_d.rdata = {29'h00000000, s_q.ists};
				ADDR_IRQ_MASK: s_d.rdata = {29'h00000000, s_q.imask};
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.slverr = 1'b1;
				end
			endcase
			if (pwrite) begin
				s_d.rdata = 32'h00000000;
			end
		end
		if (access && s_q.ready && pwrite) begin
			case (paddr)
				// host acts after the sequencer in the same cycle
				ADDR_GP_FLAGS: s_d.gp = ((s_d.gp | pwdata[SET_LSB +: 8]) &
					~pwdata[CLR_LSB +: 8]) ^ (pwdata[TGL_LSB +: 8] & TOGGLE_MASK); // R8
				ADDR_CONFIG: s_d.tsel = pwdata[1:0]; // R12
				ADDR_IRQ_STATUS: iclr = pwdata[2:0];
				ADDR_IRQ_MASK: s_d.imask = pwdata[2:0];
				default: ;
			endcase
		end

		// set beats clear so no event is lost
		s_d.ists = (s_q.ists & ~iclr) | iset;
		s_d.irq = |(s_d.ists & s_d.imask);

		// condition test, answered next cycle
		s_d.cvalid = cond_req;
		if (cond_req) begin
			s_d.ctrue = cond_pick; // R9 R19
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{gp: GP_RESET, tsel: TSEL_RESET, ists: IRQ_RESET, imask: IRQ_RESET,
				default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.slverr;
	assign cond_valid = s_q.cvalid;
	assign cond_true = s_q.ctrue;
	assign gp_flags = s_q.gp;
	assign irq = s_q.irq;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_cmp_only;
		!is_cmp && !(op_valid && op == flag_update_op) && !host_wr
			|=> $stable(gp_flags[1:0]);
	endproperty
	a_cmp_only: assert property (p_cmp_only) else $error("compare flag moved"); // R3

	property p_lt;
		op_valid && op == compare_message_timer_op && !host_wr
			|=> gp_flags[0] == ($past(op_param) < $past(msg_timer));
	endproperty
	a_lt: assert property (p_lt) else $error("less-than flag wrong"); // R4

	property p_eq;
		is_cmp && !host_wr |=> gp_flags[1] == ($past(op_param) == $past(cmp_val));
	endproperty
	a_eq: assert property (p_eq) else $error("equal flag wrong"); // R5

	property p_gp01;
		op_valid && op == flag_update_op && flag_set[1] && !flag_clr[1] && !host_wr
			|=> gp_flags[1];
	endproperty
	a_gp01: assert property (p_gp01) else $error("flag 1 not set"); // R6

	property p_tgl;
		op_valid && op == flag_update_op && flag_tgl[2] && !flag_set[2] &&
			!flag_clr[2] && !host_wr |=> gp_flags[2] != $past(gp_flags[2]);
	endproperty
	a_tgl: assert property (p_tgl) else $error("flag 2 not toggled"); // R7

	property p_host_clr;
		host_wr && pwdata[CLR_LSB + 3] && !pwdata[TGL_LSB + 3] ##1 !host_wr
			|-> !gp_flags[3];
	endproperty
	a_host_clr: assert property (p_host_clr) else $error("host clear lost"); // R8

	property p_inverse;
		cond_req && cond_sel[3:0] == COND_GBT && !msg_done
			|=> cond_valid && cond_true == (s_q.gbt ^ $past(cond_sel[4]));
	endproperty
	a_inverse: assert property (p_inverse) else $error("inverse sense wrong"); // R9

	property p_no_response_cond;
		msg_done && tif.no_response |=> s_q.no_response_cond && s_q.bad && !s_q.gbt;
	endproperty
	a_no_response_cond: assert property (p_no_response_cond) else $error("no response not kept"); // R10 R15

	property p_gbt_zero;
		msg_done && !gbt_kind |=> !s_q.gbt;
	endproperty
	a_gbt_zero: assert property (p_gbt_zero) else $error("good block on bc-rt"); // R16

	property p_gbt_set;
		msg_done && gbt_kind && !fmt_any && !tif.no_response |=> s_q.gbt;
	endproperty
	a_gbt_set: assert property (p_gbt_set) else $error("good block missing"); // R14 R17

	property p_bad;
		msg_done && !fmt_any && !msg_loop_fail && !tif.no_response |=> !s_q.bad;
	endproperty
	a_bad: assert property (p_bad) else $error("bad message on clean"); // R18

	property p_fmt;
		msg_done && msg_addr_mismatch |=> s_q.fmt ##1 cond_vec[COND_FMT];
	endproperty
	a_fmt: assert property (p_fmt) else $error("format error lost"); // R13

	property p_always;
		cond_req && (cond_sel == COND_ALWAYS || cond_sel == COND_NEVER)
			|=> cond_true == !$past(cond_sel[4]);
	endproperty
	a_always: assert property (p_always) else $error("always/never wrong"); // R19

	property p_irq;
		irq == |(s_q.ists & s_q.imask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	property p_set_wins;
		msg_done && tif.no_response |=> s_q.ists[IRQ_NO_RESPONSE_COND];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("no response event lost"); // R10

	// sticky until the host writes a one to it
	property p_sticky;
		s_q.ists[IRQ_NO_RESPONSE_COND] && !(access && pready && pwrite && paddr == ADDR_IRQ_STATUS &&
			pwdata[IRQ_NO_RESPONSE_COND]) |=> s_q.ists[IRQ_NO_RESPONSE_COND];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit dropped");

	property p_gbt_clr;
		msg_done && (fmt_any || tif.no_response) |=> !cond_vec[COND_GBT];
	endproperty
	a_gbt_clr: assert property (p_gbt_clr) else $error("good block after bad message"); // R15

	// exactly one wait state on every access
	property p_wait;
		access && !pready |=> pready;
	endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");

	c_cmp: cover property (is_cmp ##1 gp_flags[1]);
	c_no_response_cond: cover property (msg_done && tif.no_response);
	c_host: cover property (host_wr ##2 irq);
	c_gbt: cover property (msg_done && msg_kind == kind_rt_to_rt ##1 s_q.gbt);

endmodule : bc_condition_flag_unit
`default_nettype wire

// ### src/bc_flag_pkg.sv
// shared constants and types of the bc condition flag unit
package bc_flag_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_GP_FLAGS = 8'h00;
	localparam logic [7:0] ADDR_COND = 8'h04;
	localparam logic [7:0] ADDR_CONFIG = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

	// flag register field positions
	localparam int SET_LSB = 0;
	localparam int CLR_LSB = 8;
	localparam int TGL_LSB = 16;
	localparam logic [7:0] TOGGLE_MASK = 8'hfc;
	localparam logic [7:0] GP_RESET = 8'h00;
	localparam logic [1:0] TSEL_RESET = 2'h0;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// interrupt bit positions
	localparam int IRQ_CMP = 0;
	localparam int IRQ_BAD = 1;
	localparam int IRQ_NO_RESPONSE_COND = 2;

	// condition codes
	localparam logic [3:0] COND_NO_RESPONSE_COND = 4'h8;
	localparam logic [3:0] COND_FMT = 4'h9;
	localparam logic [3:0] COND_GBT = 4'ha;
	localparam logic [3:0] COND_BAD = 4'hc;
	localparam logic [4:0] COND_ALWAYS = 5'h0f;
	localparam logic [4:0] COND_NEVER = 5'h1f;

	// response timeout, nominal values
	localparam int unsigned CLK_NS = 10;
	localparam int unsigned TIMEOUT_NS_0 = 18500;
	localparam int unsigned TIMEOUT_NS_1 = 22500;
	localparam int unsigned TIMEOUT_NS_2 = 50500;
	localparam int unsigned TIMEOUT_NS_3 = 130000;
	localparam int unsigned TIMEOUT_CYC_0 = TIMEOUT_NS_0 / CLK_NS;
	localparam int unsigned TIMEOUT_CYC_1 = TIMEOUT_NS_1 / CLK_NS;
	localparam int TIMER_W = 16;

	typedef enum logic [2:0] {
		op_none,
		execute_message_op,
		compare_frame_timer_op,
		compare_message_timer_op,
		flag_update_op
	} seq_op_e;

	typedef enum logic [2:0] {
		kind_bc_to_rt,
		kind_rt_to_bc,
		kind_rt_to_rt,
		kind_mode_nodata,
		kind_mode_rx_data,
		kind_mode_tx_data
	} msg_kind_e;

endpackage : bc_flag_pkg

// ### src/responded_cond_timeout_timer.sv
// response timeout timer: parity mid-bit to status mid-sync
`timescale 1ns/1ps
`default_nettype none
module responded_cond_timeout_timer import bc_flag_pkg::*; #(
	parameter int unsigned CYC_0 = TIMEOUT_CYC_0,
	parameter int unsigned CYC_1 = TIMEOUT_CYC_1,
	parameter int unsigned CYC_2 = TIMEOUT_NS_2 / CLK_NS,
	parameter int unsigned CYC_3 = TIMEOUT_NS_3 / CLK_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// flag unit side
	responded_cond_timer_if.timer tif
);

	typedef enum logic {t_idle, t_run} tstate_e;
	typedef struct packed {
		tstate_e st;
		logic [TIMER_W-1:0] cnt;
		logic no_response_cond;
	} tstate_s;

	tstate_s s_q, s_d;
	logic [TIMER_W-1:0] limit;

	always_comb begin
		case (tif.sel)
			2'h0: limit = TIMER_W'(CYC_0);
			2'h1: limit = TIMER_W'(CYC_1);
			2'h2: limit = TIMER_W'(CYC_2);
			default: limit = TIMER_W'(CYC_3);
		endcase
	end

	always_comb begin
		s_d = s_q;
		case (s_q.st)
			t_idle: ;
			t_run: begin
				if (tif.stop) begin
					s_d.st = t_idle; // R11
				end else if (s_q.cnt == limit - TIMER_W'(1)) begin
					s_d.no_response_cond = 1'b1; // R12
					s_d.st = t_idle;
				end else begin
					s_d.cnt = s_q.cnt + TIMER_W'(1);
				end
			end
			default: s_d.st = t_idle;
		endcase
		// a new word restarts the window
		if (tif.start) begin
			s_d.st = t_run; // R11
			s_d.cnt = '0;
			s_d.no_response_cond = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{st: t_idle, cnt: '0, no_response_cond: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign tif.no_response = s_q.no_response_cond;
	assign tif.busy = (s_q.st == t_run);

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_expire;
		s_q.st == t_run && s_q.cnt == limit - TIMER_W'(1) && !tif.stop && !tif.start
			|=> tif.no_response && !tif.busy;
	endproperty
	a_expire: assert property (p_expire) else $error("timeout not flagged"); // R12

	property p_start;
		tif.start |=> tif.busy && !tif.no_response && s_q.cnt == '0;
	endproperty
	a_start: assert property (p_start) else $error("timer did not start"); // R11

endmodule : responded_cond_timeout_timer
`default_nettype wire

// ### src/responded_cond_timer_if.sv
// link between the flag unit and its response timeout timer
`timescale 1ns/1ps
`default_nettype none
interface responded_cond_timer_if;
	logic start;
	logic stop;
	logic [1:0] sel;
	logic no_response;
	logic busy;
	modport timer(input start, input stop, input sel, output no_response, output busy);
	modport user(output start, output stop, output sel, input no_response, input busy);
endinterface : responded_cond_timer_if
`default_nettype wire
